// >>> hdl/ulmc_top.sv
`timescale 1ns/1ps
module ulmc_top #(
	parameter int DEPTH = 128
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rx_in,
	output logic             tx_out,
	input  wire logic        cts_n,
	input  wire logic        dsr_n,
	input  wire logic        ri_n,
	input  wire logic        cd_n,
	output logic             rts_n,
	output logic             dtr_n,
	output logic             dtr_oe_n,
	output logic             modem_io_sel,
	input  wire logic        xoff_halt,
	input  wire logic        flow_char,
	output logic             tx_halted,
	output logic             lsr_irq
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

	////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [7:0]             line_control;
		logic [7:0]             modem_control;
		logic [7:0]             interrupt_enable_reg;
		logic [7:0]             enhanced_feature_reg;
		logic [7:0]             dll;
		logic [7:0]             dlh;
		logic [DEPTH-1:0][7:0]  txq;
		logic [AW-1:0]          twp;
		logic [AW-1:0]          trp;
		logic [AW:0]            tcnt;
		logic [DEPTH-1:0][10:0] rxq;
		logic [AW-1:0]          rwp;
		logic [AW-1:0]          rrp;
		logic [AW:0]            rcnt;
		logic [AW:0]            ecnt;
		logic                   ovr;
		logic                   seen;
		logic                   halted;
		logic                   tick;
		logic                   go;
		logic [7:0]             gd;
		logic [17:0]            bcnt;
		logic [4:0]             irc;
		logic [31:0]            prdata;
		logic                   pready;
		logic                   pslverr;
		logic                   tx;
		logic                   rts_n;
		logic                   dtr_n;
		logic                   dtr_oe_n;
		logic                   msel;
		logic                   irq;
	} ulmc_top_state_t;

	ulmc_top_state_t s, next_s;

	logic        dlab;
	logic        enh;
	logic        loop;
	logic        ir_on;
	logic [17:0] lim;
	logic        txs;
	logic        txb;
	logic        rxl;
	logic        rdone;
	logic [7:0]  rdat;
	logic [2:0]  rtag;
	logic [10:0] head;
	logic [2:0]  hvis;
	logic        temt;
	logic [7:0]  line_status;
	logic [7:0]  msr;

	////////////////////////////////////////////////////////////
	// serial engines

	ulmc_fmt_if f ();

	assign f.tick = s.tick;
	assign f.wlen = s.line_control[1:0];
	assign f.stop2 = s.line_control[ulmc_pkg::LC_STOP];
	assign f.pen = s.line_control[ulmc_pkg::LC_PEN];
	assign f.even = s.line_control[ulmc_pkg::LC_EVEN];
	assign f.force_p = s.line_control[ulmc_pkg::LC_FORCE];

	ulmc_tx u_tx (
		.clk     (clk),
		.reset_n (reset_n),
		.fmt     (f),
		.start   (s.go),
		.data    (s.gd),
		.ser     (txs),
		.busy    (txb)
	);

	ulmc_rx u_rx (
		.clk     (clk),
		.reset_n (reset_n),
		.fmt     (f),
		.ser     (rxl),
		.done    (rdone),
		.data    (rdat),
		.tags    (rtag)
	);

	////////////////////////////////////////////////////////////
	// decoded views

	assign dlab = s.line_control[ulmc_pkg::LC_DLAB];
	assign enh = s.enhanced_feature_reg[ulmc_pkg::EF_ENH];
	assign loop = s.modem_control[ulmc_pkg::MC_LOOP];
	assign ir_on = enh & s.modem_control[ulmc_pkg::MC_IR];
	assign lim = (enh & s.modem_control[ulmc_pkg::MC_PRE]) ?
		{s.dlh, s.dll, 2'b00} : {2'b00, s.dlh, s.dll};
	// receive line: local loop, infrared decoder or pin
	assign rxl = loop ? txs : ir_on ? (s.irc == 5'h00) : rx_in;
	assign head = s.rxq[s.rrp];
	// tags shown only for a held char not yet reported
	assign hvis = head[10:8] & {3{~s.seen && s.rcnt != '0}};
	assign temt = s.tcnt == '0 && !txb && !s.go;
	assign line_status = {
		s.ecnt != '0,
		temt,
		s.tcnt == '0,
		hvis[2], hvis[1], hvis[0],
		s.ovr,
		s.rcnt != '0
	};
	// status inputs; outputs folded back in loopback
	assign msr[3:0] = 4'h0;
	assign msr[7:4] = loop ?
		{s.modem_control[ulmc_pkg::MC_OP2], s.modem_control[ulmc_pkg::MC_SEL],
		 s.modem_control[ulmc_pkg::MC_DTR], s.modem_control[ulmc_pkg::MC_RTS]} :
		{~cd_n & s.msel, ~ri_n & s.msel, ~dsr_n & s.msel, ~cts_n};

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign tx_out = s.tx;
	assign rts_n = s.rts_n;
	assign dtr_n = s.dtr_n;
	assign dtr_oe_n = s.dtr_oe_n;
	assign modem_io_sel = s.msel;
	assign tx_halted = s.halted;
	assign lsr_irq = s.irq;

	////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic acc;
		logic rd;
		logic wr;
		logic rpush;
		logic rpop;
		logic tpush;
		logic tpop;
		logic epush;
		logic epop;
		acc = psel && penable && s.pready;
		rd = acc && !pwrite;
		wr = acc && pwrite;
		rpush = 1'b0;
		rpop = 1'b0;
		tpush = 1'b0;
		tpop = 1'b0;
		epush = 1'b0;
		epop = 1'b0;
		next_s = s;
		next_s.tick = 1'b0;
		next_s.go = 1'b0;

		// baud tick at sixteen per bit
		if (lim == 18'h00000) begin
			next_s.bcnt = 18'h00000;
		end else if (s.bcnt >= lim - 18'h00001) begin
			next_s.bcnt = 18'h00000;
			next_s.tick = 1'b1;
		end else begin
			next_s.bcnt = s.bcnt + 18'h00001;
		end

		// infrared pulse stretched into one low bit
		if (rx_in) begin
			next_s.irc = ulmc_pkg::IR_HOLD;
		end else if (s.tick && s.irc != 5'h00) begin
			next_s.irc = s.irc - 5'h01;
		end

		// bus setup phase: answer prepared for access phase
		next_s.pready = psel && !penable;
		next_s.pslverr = 1'b0;
		next_s.prdata = 32'h00000000;
		if (psel && !penable) begin
			unique case (paddr)
				ulmc_pkg::A_DATA:
					next_s.prdata[7:0] = dlab ? s.dll : head[7:0];
				ulmc_pkg::A_IER:
					next_s.prdata[7:0] = dlab ? s.dlh : s.interrupt_enable_reg;
				ulmc_pkg::A_EFR: next_s.prdata[7:0] = s.enhanced_feature_reg;
				ulmc_pkg::A_LCR: next_s.prdata[7:0] = s.line_control;
				ulmc_pkg::A_MCR: next_s.prdata[7:0] = s.modem_control;
				ulmc_pkg::A_LSR: next_s.prdata[7:0] = line_status;
				ulmc_pkg::A_MSR: next_s.prdata[7:0] = msr;
				default: next_s.pslverr = 1'b1;
			endcase
			if (pwrite && (paddr == ulmc_pkg::A_LSR ||
				paddr == ulmc_pkg::A_MSR)) begin
				next_s.pslverr = 1'b1;
			end
		end

		// register writes
		if (wr) begin
			unique case (paddr)
				ulmc_pkg::A_DATA: begin
					if (dlab) begin
						next_s.dll = pwdata[7:0];
					end else if (s.tcnt != FULL) begin
						next_s.txq[s.twp] = pwdata[7:0];
						tpush = 1'b1;
					end
				end
				ulmc_pkg::A_IER: begin
					if (dlab) begin
						next_s.dlh = pwdata[7:0];
					end else begin
						next_s.interrupt_enable_reg = pwdata[7:0];
					end
				end
				ulmc_pkg::A_EFR: next_s.enhanced_feature_reg = pwdata[7:0];
				ulmc_pkg::A_LCR: next_s.line_control = pwdata[7:0];
				ulmc_pkg::A_MCR: next_s.modem_control = pwdata[7:0];
				default: ;
			endcase
		end

		// register reads with side effects
		if (rd && paddr == ulmc_pkg::A_DATA && !dlab && s.rcnt != '0) begin
			rpop = 1'b1;
			epop = head[10:8] != 3'h0;
			next_s.seen = 1'b0;
		end
		if (rd && paddr == ulmc_pkg::A_LSR) begin
			next_s.ovr = 1'b0;
			next_s.seen = s.rcnt != '0;
		end

		// transmit launch from queue
		if (!txb && !s.go && s.tcnt != '0 && !s.halted) begin
			next_s.go = 1'b1;
			next_s.gd = s.txq[s.trp];
			tpop = 1'b1;
		end

		// received characters; sets win over the clears above
		if (rdone) begin
			if (enh && s.modem_control[ulmc_pkg::MC_XANY]) begin
				next_s.halted = 1'b0;
			end
			if (!(enh && s.modem_control[ulmc_pkg::MC_XANY] && flow_char)) begin
				if (s.rcnt == FULL && !rpop) begin
					next_s.ovr = 1'b1;
				end else begin
					next_s.rxq[s.rwp] = {rtag, rdat};
					rpush = 1'b1;
					epush = rtag != 3'h0;
				end
			end
		end
		if (xoff_halt) begin
			next_s.halted = 1'b1;
		end

		// queue pointers and counts
		if (tpush) begin
			next_s.twp = s.twp + 1'b1;
		end
		if (tpop) begin
			next_s.trp = s.trp + 1'b1;
		end
		if (rpush) begin
			next_s.rwp = s.rwp + 1'b1;
		end
		if (rpop) begin
			next_s.rrp = s.rrp + 1'b1;
		end
		next_s.tcnt = s.tcnt + {{AW{1'b0}}, tpush} - {{AW{1'b0}}, tpop};
		next_s.rcnt = s.rcnt + {{AW{1'b0}}, rpush} - {{AW{1'b0}}, rpop};
		next_s.ecnt = s.ecnt + {{AW{1'b0}}, epush} - {{AW{1'b0}}, epop};

		// pins
		if (loop) begin
			next_s.tx = 1'b1;
		end else if (s.line_control[ulmc_pkg::LC_BRK]) begin
			next_s.tx = 1'b0;
		end else if (ir_on) begin
			next_s.tx = ~txs && f.phase < {2'b00, ulmc_pkg::IR_TICKS};
		end else begin
			next_s.tx = txs;
		end
		next_s.dtr_n = loop | ~s.modem_control[ulmc_pkg::MC_DTR];
		next_s.rts_n = loop | ~s.modem_control[ulmc_pkg::MC_RTS];
		next_s.msel = s.modem_control[ulmc_pkg::MC_SEL];
		next_s.dtr_oe_n = ~s.modem_control[ulmc_pkg::MC_SEL];
		next_s.irq = s.interrupt_enable_reg[ulmc_pkg::IE_LSI] && (s.ovr || hvis != 3'h0);
	end

	////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s <= '0;
			s.line_control <= ulmc_pkg::REG_RST;
			s.modem_control <= ulmc_pkg::REG_RST;
			s.interrupt_enable_reg <= ulmc_pkg::REG_RST;
			s.enhanced_feature_reg <= ulmc_pkg::REG_RST;
			s.dll <= ulmc_pkg::DIV_RST[7:0];
			s.dlh <= ulmc_pkg::DIV_RST[15:8];
			s.tx <= 1'b1;
			s.rts_n <= 1'b1;
			s.dtr_n <= 1'b1;
			s.dtr_oe_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end
endmodule : ulmc_top

// >>> pkg/ulmc_pkg.sv
// Operation
// - line_control bits 1:0 pick 5, 6, 7 or 8 data bits.
// - stop bit set gives 1.5 stops at 5 bits, else 2.
// - parity enable adds a parity bit on transmit, checks it on receive.
// - parity type clear means odd, set means even, both directions.
// - forced parity is 1 when type clear, 0 when type set.
// - break bit holds serial output low until cleared; loopback holds it high instead.
// - divisor access bit maps shared data offsets onto divisor latches.
// - terminal ready pin is the inverse of its control bit; loopback holds it high.
// - request to send pin is the inverse of its control bit; loopback holds it high.
// - select bit routes four pins to modem use; feeds ring in loopback.
// - loopback bit closes local loops; user output two seen only there.
// - resume-on-any: any received char restarts halted transmitter.
// - infrared bit routes serial lines via encoder and decoder, idle low.
// - prescaler bit divides baud clock by four.
// - overrun interrupts at once, char errors when at receive head.
// - data ready set while any received char is held.
// - char arriving to full queue sets overrun, queue untouched.
// - parity and framing bits describe the readable char.
// - long low line stores one break char; holds until line high.
// - holding empty mirrors an empty transmit queue.
// - transmitter empty when queue and shifter both idle.
// - error flag set while any queued byte carries an error tag.
// - in loopback clear-to-send status follows request-to-send bit.
package ulmc_pkg;
	localparam logic [7:0]  A_DATA    = 8'h00;
	localparam logic [7:0]  A_IER     = 8'h04;
	localparam logic [7:0]  A_EFR     = 8'h08;
	localparam logic [7:0]  A_LCR     = 8'h0C;
	localparam logic [7:0]  A_MCR     = 8'h10;
	localparam logic [7:0]  A_LSR     = 8'h14;
	localparam logic [7:0]  A_MSR     = 8'h18;
	localparam int          LC_STOP   = 2;
	localparam int          LC_PEN    = 3;
	localparam int          LC_EVEN   = 4;
	localparam int          LC_FORCE  = 5;
	localparam int          LC_BRK    = 6;
	localparam int          LC_DLAB   = 7;
	localparam int          MC_DTR    = 0;
	localparam int          MC_RTS    = 1;
	localparam int          MC_SEL    = 2;
	localparam int          MC_OP2    = 3;
	localparam int          MC_LOOP   = 4;
	localparam int          MC_XANY   = 5;
	localparam int          MC_IR     = 6;
	localparam int          MC_PRE    = 7;
	localparam int          EF_ENH    = 4;
	localparam int          IE_LSI    = 2;
	localparam logic [7:0]  REG_RST   = 8'h00;
	localparam logic [15:0] DIV_RST   = 16'h0001;
	localparam logic [5:0]  BIT_TICKS = 6'h10;
	localparam logic [5:0]  STOP_1H   = 6'h18;
	localparam logic [5:0]  STOP_2    = 6'h20;
	localparam logic [3:0]  MID_TICK  = 4'h7;
	localparam logic [3:0]  IR_TICKS  = 4'h3;
	localparam logic [4:0]  IR_HOLD   = 5'h10;
	typedef enum logic [2:0] {
		tx_idle = 3'b000, tx_start = 3'b001, tx_data = 3'b010,
		tx_par = 3'b011, tx_stop = 3'b100
	} ulmc_tx_st_t;
	typedef enum logic [2:0] {
		rx_idle = 3'b000, rx_start = 3'b001, rx_data = 3'b010,
		rx_par = 3'b011, rx_stop = 3'b100, rx_brk = 3'b101
	} ulmc_rx_st_t;
	function automatic logic ulmc_par(input logic [7:0] d,
		input logic [1:0] wl, input logic ev, input logic fo);
		logic [7:0] m;
		m = d & (8'hFF >> (2'h3 - wl));
		return fo ? ~ev : ((^m) ^ ~ev);
	endfunction : ulmc_par
endpackage : ulmc_pkg

// >>> pkg/ulmc_fmt_if.sv
`timescale 1ns/1ps
interface ulmc_fmt_if;
	logic       tick;
	logic [1:0] wlen;
	logic       stop2;
	logic       pen;
	logic       even;
	logic       force_p;
	logic [5:0] phase;
	modport tx (input tick, wlen, stop2, pen, even, force_p, output phase);
	modport rx (input tick, wlen, pen, even, force_p);
endinterface : ulmc_fmt_if

// >>> hdl/ulmc_tx.sv
`timescale 1ns/1ps
module ulmc_tx (
	input  wire logic       clk,
	input  wire logic       reset_n,
	ulmc_fmt_if.tx          fmt,
	input  wire logic       start,
	input  wire logic [7:0] data,
	output logic            ser,
	output logic            busy
);
	typedef struct packed {
		ulmc_pkg::ulmc_tx_st_t st;
		logic [7:0]            sh;
		logic [2:0]            nb;
		logic [5:0]            tc;
		logic                  p;
		logic                  ser;
	} ulmc_tx_state_t;
	ulmc_tx_state_t s, next_s;
	logic [5:0]     lim;
	logic           fin;
	assign lim = (s.st != ulmc_pkg::tx_stop || !fmt.stop2) ?
		ulmc_pkg::BIT_TICKS : (fmt.wlen == 2'h0) ? ulmc_pkg::STOP_1H :
		ulmc_pkg::STOP_2;
	assign fin = fmt.tick && s.tc == lim - 6'h01;
	assign ser = s.ser;
	assign busy = s.st != ulmc_pkg::tx_idle;
	assign fmt.phase = s.tc;
	always_comb begin
		next_s = s;
		if (fmt.tick) begin
			next_s.tc = fin ? 6'h00 : s.tc + 6'h01;
		end
		unique case (s.st)
			ulmc_pkg::tx_idle: begin
				next_s.ser = 1'b1;
				next_s.tc = 6'h00;
				if (start) begin
					next_s.st = ulmc_pkg::tx_start;
					next_s.sh = data;
					next_s.p = ulmc_pkg::ulmc_par(data, fmt.wlen, fmt.even,
						fmt.force_p);
					next_s.ser = 1'b0;
				end
			end
			ulmc_pkg::tx_start: if (fin) begin
				next_s.st = ulmc_pkg::tx_data;
				next_s.nb = 3'h0;
				next_s.ser = s.sh[0];
			end
			ulmc_pkg::tx_data: if (fin) begin
				next_s.sh = s.sh >> 1;
				next_s.nb = s.nb + 3'h1;
				next_s.ser = s.sh[1];
				if (s.nb == 3'h4 + {1'b0, fmt.wlen}) begin
					next_s.st = fmt.pen ? ulmc_pkg::tx_par : ulmc_pkg::tx_stop;
					next_s.ser = fmt.pen ? s.p : 1'b1;
				end
			end
			ulmc_pkg::tx_par: if (fin) begin
				next_s.st = ulmc_pkg::tx_stop;
				next_s.ser = 1'b1;
			end
			ulmc_pkg::tx_stop: if (fin) begin
				next_s.st = ulmc_pkg::tx_idle;
			end
			default: next_s.st = ulmc_pkg::tx_idle;
		endcase
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s <= '0;
			s.ser <= 1'b1;
		end else begin
			s <= next_s;
		end
	end
endmodule : ulmc_tx

// >>> hdl/ulmc_rx.sv
`timescale 1ns/1ps
module ulmc_rx (
	input  wire logic       clk,
	input  wire logic       reset_n,
	ulmc_fmt_if.rx          fmt,
	input  wire logic       ser,
	output logic            done,
	output logic [7:0]      data,
	output logic [2:0]      tags
);
	typedef struct packed {
		ulmc_pkg::ulmc_rx_st_t st;
		logic [7:0]            sh;
		logic [2:0]            nb;
		logic [3:0]            tc;
		logic                  p;
		logic                  z;
		logic                  done;
		logic [7:0]            data;
		logic [2:0]            tags;
	} ulmc_rx_state_t;
	ulmc_rx_state_t s, next_s;
	logic           smp;
	assign smp = fmt.tick && s.tc == 4'hF;
	assign done = s.done;
	assign data = s.data;
	assign tags = s.tags;
	always_comb begin
		logic [7:0] al;
		al = s.sh >> (2'h3 - fmt.wlen);
		next_s = s;
		next_s.done = 1'b0;
		if (fmt.tick) begin
			next_s.tc = s.tc + 4'h1;
		end
		if (smp) begin
			next_s.z = s.z & ~ser;
		end
		unique case (s.st)
			ulmc_pkg::rx_idle: if (!ser) begin
				next_s.st = ulmc_pkg::rx_start;
				next_s.tc = 4'h0;
				next_s.z = 1'b1;
			end
			ulmc_pkg::rx_start: if (fmt.tick && s.tc == ulmc_pkg::MID_TICK) begin
				next_s.st = ser ? ulmc_pkg::rx_idle : ulmc_pkg::rx_data;
				next_s.tc = 4'h0;
				next_s.nb = 3'h0;
			end
			ulmc_pkg::rx_data: if (smp) begin
				next_s.sh = {ser, s.sh[7:1]};
				next_s.nb = s.nb + 3'h1;
				if (s.nb == 3'h4 + {1'b0, fmt.wlen}) begin
					next_s.st = fmt.pen ? ulmc_pkg::rx_par : ulmc_pkg::rx_stop;
				end
			end
			ulmc_pkg::rx_par: if (smp) begin
				next_s.p = ser;
				next_s.st = ulmc_pkg::rx_stop;
			end
			ulmc_pkg::rx_stop: if (smp) begin
				next_s.done = 1'b1;
				next_s.data = al;
				next_s.tags[0] = fmt.pen && (s.p != ulmc_pkg::ulmc_par(al,
					fmt.wlen, fmt.even, fmt.force_p));
				next_s.tags[1] = ~ser;
				next_s.tags[2] = s.z & ~ser;
				next_s.st = (s.z & ~ser) ? ulmc_pkg::rx_brk : ulmc_pkg::rx_idle;
			end
			ulmc_pkg::rx_brk: if (ser) begin
				next_s.st = ulmc_pkg::rx_idle;
			end
			default: next_s.st = ulmc_pkg::rx_idle;
		endcase
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule : ulmc_rx

// >>> tb/ulmc_checker.sv
`timescale 1ns/1ps
module ulmc_checker #(
	parameter int DEPTH = 128
) (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        tx_out,
	input wire logic        rts_n,
	input wire logic        dtr_n,
	input wire logic        dtr_oe_n,
	input wire logic        modem_io_sel,
	input wire logic        lsr_irq
);
	logic [7:0] lcr_sh;
	logic [7:0] mcr_sh;
	logic [7:0] ier_sh;
	logic       wr;
	logic       rd_lsr;
	assign wr = psel & penable & pready & pwrite;
	assign rd_lsr = psel & penable & pready & ~pwrite
		& (paddr == ulmc_pkg::A_LSR);
	////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			lcr_sh <= 8'h00;
			mcr_sh <= 8'h00;
			ier_sh <= 8'h00;
		end else if (wr) begin
			if (paddr == ulmc_pkg::A_LCR)
				lcr_sh <= pwdata[7:0];
			if (paddr == ulmc_pkg::A_MCR)
				mcr_sh <= pwdata[7:0];
			if (paddr == ulmc_pkg::A_IER && !lcr_sh[7])
				ier_sh <= pwdata[7:0];
		end
	end
	////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	dtr_pin_a: assert property (
		mcr_sh == $past(mcr_sh) |-> dtr_n == (mcr_sh[4] | ~mcr_sh[0]))
		else $error("dtr pin level wrong");
	rts_pin_a: assert property (
		$stable(mcr_sh) |-> rts_n == (mcr_sh[4] | ~mcr_sh[1]))
		else $error("rts pin level wrong");
	sel_pin_a: assert property (
		$stable(mcr_sh) |-> modem_io_sel == mcr_sh[2]
		&& dtr_oe_n == !mcr_sh[2])
		else $error("modem select routing wrong");
	brk_line_a: assert property (
		lcr_sh[6] && !mcr_sh[4] && !mcr_sh[6] && $stable(lcr_sh)
		&& $stable(mcr_sh) |-> !tx_out)
		else $error("break not held on line");
	irq_mask_a: assert property (
		!ier_sh[2] && !$past(ier_sh[2]) |-> !lsr_irq)
		else $error("line irq while disabled");
	ovr_irq_a: assert property (
		rd_lsr && prdata[1] && ier_sh[2] |-> lsr_irq || $past(lsr_irq))
		else $error("overrun without irq");
	temt_a: assert property (
		rd_lsr && prdata[6] |-> prdata[5])
		else $error("tx empty with holding data");
	err_sum_a: assert property (
		rd_lsr && (|prdata[4:2]) |-> prdata[7] && prdata[0])
		else $error("head tag without error summary");
	ready_a: assert property (
		psel && !penable |=> pready ##1 !pready)
		else $error("pready not one cycle");
endmodule : ulmc_checker
bind ulmc_top ulmc_checker #(.DEPTH(DEPTH)) chk (.clk, .reset_n, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .tx_out,
	.rts_n, .dtr_n, .dtr_oe_n, .modem_io_sel, .lsr_irq);

// >>> tb/ulmc_partner.sv
`timescale 1ns/1ps
module ulmc_partner (
	input  wire logic clk,
	output logic      rx_in,
	output logic      cts_n,
	output logic      dsr_n,
	output logic      ri_n,
	output logic      cd_n
);
	initial begin
		rx_in = 1'h1;
		{cts_n, dsr_n, ri_n, cd_n} = 4'hF;
	end
	task automatic bit_out(input logic b);
		@(posedge clk);
		rx_in <= b;
		repeat (15) @(posedge clk);
	endtask : bit_out
	task automatic send(input logic [7:0] d, input int n, input logic pen,
		input logic pb, input logic sb);
		bit_out(1'h0);
		for (int i = 0; i < n; i++)
			bit_out(d[i]);
		if (pen)
			bit_out(pb);
		bit_out(sb);
		bit_out(1'h1);
	endtask : send
	task automatic hold_low(input int bits);
		repeat (bits) bit_out(1'h0);
		bit_out(1'h1);
	endtask : hold_low
endmodule : ulmc_partner

// >>> tb/test_uart_line_modem_control_status.sv
`timescale 1ns/1ps
module test_uart_line_modem_control_status;
	logic        clk, reset_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic        rx_in, tx_out, cts_n, dsr_n, ri_n, cd_n, rts_n, dtr_n;
	logic        dtr_oe_n, modem_io_sel, xoff_halt, flow_char, tx_halted;
	logic        lsr_irq, err;
	int          miscompares, num_checks;
	logic [7:0]  fmts [6] = '{8'h00, 8'h04, 8'h09, 8'h1A, 8'h2B, 8'h3F};
	ulmc_top #(.DEPTH(8)) dut (.clk, .reset_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .rx_in, .tx_out,
		.cts_n, .dsr_n, .ri_n, .cd_n, .rts_n, .dtr_n, .dtr_oe_n,
		.modem_io_sel, .xoff_halt, .flow_char, .tx_halted, .lsr_irq);
	ulmc_partner far (.clk, .rx_in, .cts_n, .dsr_n, .ri_n, .cd_n);
	////////////////////////////////////////
	task automatic summarize;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic chkb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chkb
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (pready !== 1'h1) begin
			miscompares++;
			summarize();
		end
		r = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic poll(input logic [7:0] a, input int b);
		for (int i = 0; i < 100; i++) begin
			apb(1'h0, a, 8'h00);
			if (r[b] === 1'h1)
				return;
		end
		miscompares++;
		summarize();
	endtask : poll
	////////////////////////////////////////
	task automatic t_regs;
		apb(1'h0, ulmc_pkg::A_LCR, 8'h00);
		chk(r, 32'h00000000);
		apb(1'h0, ulmc_pkg::A_MCR, 8'h00);
		chk(r, 32'h00000000);
		apb(1'h0, ulmc_pkg::A_LSR, 8'h00);
		chk(r, 32'h00000060);
		apb(1'h1, ulmc_pkg::A_LSR, 8'hFF);
		chkb(err, 1'h1);
		apb(1'h0, 8'h1C, 8'h00);
		chk({r[31:1], err}, 32'h00000001);
		apb(1'h1, ulmc_pkg::A_LCR, 8'h83);
		apb(1'h1, ulmc_pkg::A_DATA, 8'h05);
		apb(1'h0, ulmc_pkg::A_DATA, 8'h00);
		chk(r, 32'h00000005);
		apb(1'h1, ulmc_pkg::A_DATA, 8'h01);
		apb(1'h1, ulmc_pkg::A_LCR, 8'h03);
		apb(1'h0, ulmc_pkg::A_LSR, 8'h00);
		chk(r, 32'h00000060);
	endtask : t_regs
	task automatic t_tx(input logic [7:0] line_control, input logic [7:0] d);
		int n, p, st, fr, c;
		logic [7:0] m;
		logic pb;
		n = line_control[1:0] + 5;
		p = line_control[3];
		st = line_control[2] ? (n == 5 ? 24 : 32) : 16;
		fr = 16 * (1 + n + p) + st;
		m = d & (8'hFF >> (8 - n));
		pb = line_control[5] ? ~line_control[4] : (line_control[4] ? ^m : ~^m);
		apb(1'h1, ulmc_pkg::A_LCR, line_control);
		fork
			begin
				apb(1'h1, ulmc_pkg::A_DATA, d);
				apb(1'h1, ulmc_pkg::A_DATA, d);
			end
			begin
				for (c = 0; c < 60 && tx_out !== 1'h0; c++)
					@(negedge clk);
				repeat (8) @(negedge clk);
				chkb(tx_out, 1'h0);
				for (int i = 0; i < n; i++) begin
					repeat (16) @(negedge clk);
					chkb(tx_out, d[i]);
				end
				if (p) begin
					repeat (16) @(negedge clk);
					chkb(tx_out, pb);
				end
				repeat (16) @(negedge clk);
				chkb(tx_out, 1'h1);
				for (c = 24 + 16 * (n + p); c < fr + 9 && tx_out !== 1'h0; c++)
					@(negedge clk);
				chkb(c >= fr && c <= fr + 4, 1'h1);
			end
		join
		poll(ulmc_pkg::A_LSR, 6);
		chk(r, 32'h00000060);
	endtask : t_tx
	task automatic t_brk;
		apb(1'h1, ulmc_pkg::A_LCR, 8'h43);
		repeat (40) @(negedge clk);
		chkb(tx_out, 1'h0);
		apb(1'h1, ulmc_pkg::A_LCR, 8'h03);
		repeat (4) @(negedge clk);
		chkb(tx_out, 1'h1);
	endtask : t_brk
	task automatic t_modem;
		apb(1'h1, ulmc_pkg::A_MCR, 8'h07);
		repeat (2) @(negedge clk);
		chk({28'h0, dtr_n, rts_n, dtr_oe_n, modem_io_sel}, 32'h1);
		apb(1'h1, ulmc_pkg::A_MCR, 8'h00);
		repeat (2) @(negedge clk);
		chk({28'h0, dtr_n, rts_n, dtr_oe_n, modem_io_sel}, 32'hE);
	endtask : t_modem
	task automatic t_loop;
		apb(1'h1, ulmc_pkg::A_MCR, 8'h12);
		apb(1'h0, ulmc_pkg::A_MSR, 8'h00);
		chkb(r[4], 1'h1);
		chk({30'h0, tx_out, rts_n}, 32'h3);
		apb(1'h1, ulmc_pkg::A_DATA, 8'hC3);
		poll(ulmc_pkg::A_LSR, 0);
		apb(1'h0, ulmc_pkg::A_DATA, 8'h00);
		chk(r, 32'h000000C3);
		apb(1'h1, ulmc_pkg::A_MCR, 8'h00);
	endtask : t_loop
	task automatic t_rx_err;
		apb(1'h1, ulmc_pkg::A_LCR, 8'h1B);
		far.send(8'h3C, 8, 1'h1, 1'h1, 1'h1);
		far.send(8'h5A, 8, 1'h1, 1'h0, 1'h0);
		apb(1'h0, ulmc_pkg::A_LSR, 8'h00);
		chk(r, 32'h000000E5);
		apb(1'h0, ulmc_pkg::A_DATA, 8'h00);
		chk(r, 32'h0000003C);
		apb(1'h0, ulmc_pkg::A_LSR, 8'h00);
		chk(r, 32'h000000E9);
		apb(1'h0, ulmc_pkg::A_DATA, 8'h00);
		chk(r, 32'h0000005A);
		apb(1'h0, ulmc_pkg::A_LSR, 8'h00);
		chk(r, 32'h00000060);
	endtask : t_rx_err
	task automatic t_ovr;
		apb(1'h1, ulmc_pkg::A_LCR, 8'h03);
		apb(1'h1, ulmc_pkg::A_IER, 8'h04);
		for (int i = 1; i <= 9; i++)
			far.send(8'(i), 8, 1'h0, 1'h0, 1'h1);
		@(negedge clk);
		chkb(lsr_irq, 1'h1);
		apb(1'h0, ulmc_pkg::A_LSR, 8'h00);
		chk(r, 32'h00000063);
		apb(1'h0, ulmc_pkg::A_LSR, 8'h00);
		chk(r, 32'h00000061);
		for (int i = 1; i <= 8; i++) begin
			apb(1'h0, ulmc_pkg::A_DATA, 8'h00);
			chk(r, 32'(i));
		end
		apb(1'h0, ulmc_pkg::A_LSR, 8'h00);
		chk(r, 32'h00000060);
		chkb(lsr_irq, 1'h0);
	endtask : t_ovr
	task automatic t_brk_rx;
		far.hold_low(24);
		apb(1'h0, ulmc_pkg::A_LSR, 8'h00);
		chk(r, 32'h000000F9);
		apb(1'h0, ulmc_pkg::A_DATA, 8'h00);
		chk(r, 32'h00000000);
		apb(1'h0, ulmc_pkg::A_LSR, 8'h00);
		chk(r, 32'h00000060);
	endtask : t_brk_rx
	task automatic t_xany;
		apb(1'h1, ulmc_pkg::A_EFR, 8'h10);
		apb(1'h1, ulmc_pkg::A_MCR, 8'h20);
		xoff_halt <= 1'h1;
		@(posedge clk);
		xoff_halt <= 1'h0;
		repeat (2) @(negedge clk);
		chkb(tx_halted, 1'h1);
		far.send(8'h77, 8, 1'h0, 1'h0, 1'h1);
		chkb(tx_halted, 1'h0);
		apb(1'h0, ulmc_pkg::A_DATA, 8'h00);
		chk(r, 32'h00000077);
		apb(1'h1, ulmc_pkg::A_MCR, 8'h00);
		apb(1'h1, ulmc_pkg::A_EFR, 8'h00);
	endtask : t_xany
	////////////////////////////////////////
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	initial begin
		{reset_n, psel, penable, pwrite, xoff_halt, flow_char} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		miscompares = 0;
		num_checks = 0;
		repeat (16) @(posedge clk);
		reset_n <= 1'h1;
		t_regs();
		foreach (fmts[k])
			t_tx(fmts[k], 8'hB5);
		t_brk();
		t_modem();
		t_loop();
		t_rx_err();
		t_ovr();
		t_brk_rx();
		t_xany();
		summarize();
	end
endmodule : test_uart_line_modem_control_status
